// [rtdib_pkg.sv]
// Constants and types shared by the resistance input parameter block
package rtdib_pkg;
	// ---------------------------------------------------------------
	// Parameter byte positions (object index 3100h plus position)
	// ---------------------------------------------------------------
	localparam logic [2:0] IDX_DIAG = 3'h0;
	localparam logic [2:0] IDX_OPEN = 3'h1;
	localparam logic [2:0] IDX_UNIT = 3'h2;
	localparam logic [2:0] IDX_MAINS = 3'h3;
	localparam logic [2:0] IDX_CH0 = 3'h4;
	localparam logic [15:0] OBJ_INDEX_BASE = 16'h3100;
	localparam logic [7:0] SUBIDX_BASE = 8'h01;
	// ---------------------------------------------------------------
	// Record set numbers
	// ---------------------------------------------------------------
	localparam logic [7:0] SET_ENABLES = 8'h00;
	localparam logic [7:0] SET_UNIT_MAINS = 8'h01;
	localparam logic [7:0] SET_CH0 = 8'h80;
	// ---------------------------------------------------------------
	// Field codes and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] DIAG_OFF = 8'h00;
	localparam logic [7:0] DIAG_ON = 8'h40;
	localparam int DIAG_BIT = 6;
	localparam logic [7:0] OPEN_RST = 8'h00;
	localparam logic [1:0] UNIT_C = 2'h0;
	localparam logic [1:0] UNIT_F = 2'h1;
	localparam logic [1:0] UNIT_K = 2'h2;
	localparam logic [1:0] MAINS_60 = 2'h1;
	localparam logic [1:0] MAINS_50 = 2'h2;
	localparam logic [7:0] RANGE_RST = 8'h50;
	localparam logic [7:0] RANGE_OFF = 8'hff;
	localparam logic [7:0] FN_2W = 8'h50;
	localparam logic [7:0] FN_3W = 8'h58;
	localparam logic [7:0] FN_4W = 8'h60;
	localparam logic [7:0] FN_R2W = 8'h70;
	localparam logic [7:0] FN_R3W = 8'h78;
	localparam logic [7:0] FN_R4W = 8'h80;
	localparam logic [7:0] FN_SENSORS = 8'h05;
	localparam logic [7:0] FN_RES_SPANS = 8'h03;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	// ---------------------------------------------------------------
	// Value bands in tenths of a degree Celsius, or counts
	// ---------------------------------------------------------------
	localparam logic signed [17:0] PT_HI = 18'sd10000;
	localparam logic signed [17:0] PT_NHI = 18'sd8500;
	localparam logic signed [17:0] PT_NLO = -18'sd2000;
	localparam logic signed [17:0] PT_LO = -18'sd2430;
	localparam logic signed [17:0] NI_HI = 18'sd2950;
	localparam logic signed [17:0] NI_NHI = 18'sd2500;
	localparam logic signed [17:0] NI_NLO = -18'sd600;
	localparam logic signed [17:0] NI_LO = -18'sd1050;
	localparam logic signed [17:0] N120_HI = 18'sd4000;
	localparam logic signed [17:0] N120_NHI = 18'sd3200;
	localparam logic signed [17:0] N120_NLO = -18'sd800;
	localparam logic signed [17:0] N120_LO = -18'sd1000;
	localparam logic signed [17:0] RES_HI = 18'sd32767;
	localparam logic signed [17:0] RES_LO = 18'sd0;
	localparam logic signed [19:0] F_MUL = 20'sd9;
	localparam logic signed [19:0] F_DIV = 20'sd5;
	localparam logic signed [19:0] F_OFS = 20'sd320;
	localparam logic signed [17:0] K_OFS = 18'sd2732;

	typedef enum logic [2:0] {CLS_OFF, CLS_PT, CLS_NI, CLS_N120, CLS_RES, CLS_BAD} rtdib_cls_t;
endpackage : rtdib_pkg

// [rtdib_decode.sv]
// Function number decoder: sensor class of one channel
`timescale 1ns/10ps
module rtdib_decode (
	input wire logic [7:0] code,
	output rtdib_pkg::rtdib_cls_t cls
);
	logic [7:0] o2;
	logic [7:0] o3;
	logic [7:0] o4;
	logic [7:0] sel;
	logic hit;

	always_comb begin
		o2 = code - rtdib_pkg::FN_2W;
		o3 = code - rtdib_pkg::FN_3W;
		o4 = code - rtdib_pkg::FN_4W;
		hit = 1'b1;
		sel = 8'h00;
		if (o2 < rtdib_pkg::FN_SENSORS) begin
			sel = o2;
		end else if (o3 < rtdib_pkg::FN_SENSORS) begin
			sel = o3;
		end else if (o4 < rtdib_pkg::FN_SENSORS) begin
			sel = o4;
		end else begin
			hit = 1'b0;
		end
		if (code == rtdib_pkg::RANGE_OFF) begin
			cls = rtdib_pkg::CLS_OFF;
		end else if (hit) begin
			// Group order: Pt100, Pt1000, Ni100, Ni1000, Ni120
			if (sel < 8'h02) begin
				cls = rtdib_pkg::CLS_PT;
			end else if (sel < 8'h04) begin
				cls = rtdib_pkg::CLS_NI;
			end else begin
				cls = rtdib_pkg::CLS_N120;
			end
		end else if ((8'(code - rtdib_pkg::FN_R2W) < rtdib_pkg::FN_RES_SPANS)
				|| (8'(code - rtdib_pkg::FN_R3W) < rtdib_pkg::FN_RES_SPANS)
				|| (8'(code - rtdib_pkg::FN_R4W) < rtdib_pkg::FN_RES_SPANS)) begin
			cls = rtdib_pkg::CLS_RES;
		end else begin
			cls = rtdib_pkg::CLS_BAD;
		end
	end
endmodule : rtdib_decode

// [rtdib_scale.sv]
// Band limiting and unit conversion of one raw measurement
`timescale 1ns/10ps
module rtdib_scale (
	input wire rtdib_pkg::rtdib_cls_t cls,
	input wire logic [1:0] unit,
	input wire logic signed [17:0] raw,
	output logic [15:0] value,
	output logic over,
	output logic under,
	output logic clamped
);
	logic signed [17:0] hi;
	logic signed [17:0] lo;
	logic signed [17:0] nhi;
	logic signed [17:0] nlo;
	logic signed [17:0] lim;
	logic signed [19:0] fah;

	always_comb begin
		unique case (cls)
			rtdib_pkg::CLS_PT: begin
				hi = rtdib_pkg::PT_HI;
				lo = rtdib_pkg::PT_LO;
				nhi = rtdib_pkg::PT_NHI;
				nlo = rtdib_pkg::PT_NLO;
			end
			rtdib_pkg::CLS_NI: begin
				hi = rtdib_pkg::NI_HI;
				lo = rtdib_pkg::NI_LO;
				nhi = rtdib_pkg::NI_NHI;
				nlo = rtdib_pkg::NI_NLO;
			end
			rtdib_pkg::CLS_N120: begin
				hi = rtdib_pkg::N120_HI;
				lo = rtdib_pkg::N120_LO;
				nhi = rtdib_pkg::N120_NHI;
				nlo = rtdib_pkg::N120_NLO;
			end
			default: begin
				hi = rtdib_pkg::RES_HI;
				lo = rtdib_pkg::RES_LO;
				nhi = rtdib_pkg::RES_HI;
				nlo = rtdib_pkg::RES_LO;
			end
		endcase
		over = raw > nhi;
		under = raw < nlo;
		clamped = (raw > hi) || (raw < lo);
		lim = (raw > hi) ? hi : ((raw < lo) ? lo : raw);
		// Clamp before converting so unit choice never moves the band edges
		fah = (20'(lim) * rtdib_pkg::F_MUL) / rtdib_pkg::F_DIV + rtdib_pkg::F_OFS;
		if (cls == rtdib_pkg::CLS_RES || unit == rtdib_pkg::UNIT_C) begin
			value = lim[15:0];
		end else if (unit == rtdib_pkg::UNIT_F) begin
			value = fah[15:0];
		end else begin
			value = 16'(lim + rtdib_pkg::K_OFS);
		end
	end
endmodule : rtdib_scale

// [rtdib_param.sv]
// Parameter record store and process value path of the four channel input
`timescale 1ns/10ps
module rtdib_param #(
	parameter int NUM_CH = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic two_ch_strap,
	input wire logic sys_stopped,
	input wire logic par_wr,
	input wire logic par_rd,
	input wire logic [2:0] par_pos,
	input wire logic [7:0] record_set_number,
	input wire logic [7:0] par_wdata,
	output logic par_wack,
	output logic par_werr,
	output logic par_rvalid,
	output logic [7:0] par_rdata,
	output logic diag_irq_en,
	output logic [3:0] open_circuit_en,
	output logic [1:0] temp_unit,
	output logic mains_60hz,
	output logic [3:0] chan_active,
	output logic [3:0] chan_param_err,
	input wire logic meas_valid,
	input wire logic [1:0] meas_chan,
	input wire logic signed [17:0] meas_raw,
	output logic pv_valid,
	output logic [1:0] pv_chan,
	output logic [15:0] pv_value,
	output logic pv_over,
	output logic pv_under,
	output logic pv_clamped
);
	if (NUM_CH != 4) begin : g_bad_ch
		$error("rtdib_param serves exactly four channels");
	end

	// ---------------------------------------------------------------
	// Strap capture after reset release
	// ---------------------------------------------------------------
	logic strap_s1_q;
	logic strap_s2_q;
	logic [1:0] init_cnt_q;
	logic init_done;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
		end else begin
			strap_s1_q <= two_ch_strap;
			strap_s2_q <= strap_s1_q;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_cnt_q <= 2'h0;
		end else if (init_cnt_q != rtdib_pkg::STRAP_WAIT) begin
			init_cnt_q <= init_cnt_q + 2'h1;
		end
	end

	assign init_done = init_cnt_q == rtdib_pkg::STRAP_WAIT;

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	logic [7:0] rng_q [4];
	logic [7:0] exp_set;
	logic set_ok;
	logic data_ok;
	logic stop_ok;
	logic wr_ok;
	logic [1:0] wr_ch;
	rtdib_pkg::rtdib_cls_t cls [4];
	rtdib_pkg::rtdib_cls_t wr_cls;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_dec
			rtdib_decode u_dec (
				.code(rng_q[g]),
				.cls(cls[g])
			);
			assign chan_active[g] = (cls[g] != rtdib_pkg::CLS_OFF)
				&& (cls[g] != rtdib_pkg::CLS_BAD);
		end
	endgenerate

	rtdib_decode u_wr_dec (
		.code(par_wdata),
		.cls(wr_cls)
	);

	assign wr_ch = 2'(par_pos - rtdib_pkg::IDX_CH0);

	always_comb begin
		if (par_pos < rtdib_pkg::IDX_UNIT) begin
			exp_set = rtdib_pkg::SET_ENABLES;
		end else if (par_pos < rtdib_pkg::IDX_CH0) begin
			exp_set = rtdib_pkg::SET_UNIT_MAINS;
		end else begin
			exp_set = rtdib_pkg::SET_CH0 + 8'(wr_ch);
		end
		unique case (par_pos)
			rtdib_pkg::IDX_DIAG: data_ok = (par_wdata == rtdib_pkg::DIAG_OFF)
				|| (par_wdata == rtdib_pkg::DIAG_ON);
			rtdib_pkg::IDX_OPEN: data_ok = 1'b1;
			rtdib_pkg::IDX_UNIT: data_ok = par_wdata[1:0] != 2'h3;
			rtdib_pkg::IDX_MAINS: data_ok = (par_wdata[1:0] == rtdib_pkg::MAINS_60)
				|| (par_wdata[1:0] == rtdib_pkg::MAINS_50);
			default: data_ok = wr_cls != rtdib_pkg::CLS_BAD;
		endcase
	end

	assign set_ok = record_set_number == exp_set;
	// The enable record is refused while running so a stray write cannot arm wire checks
	assign stop_ok = sys_stopped || (exp_set != rtdib_pkg::SET_ENABLES);
	assign wr_ok = par_wr && init_done && set_ok && stop_ok && data_ok;

	// ---------------------------------------------------------------
	// Parameter registers
	// ---------------------------------------------------------------
	logic diag_q;
	logic [3:0] open_q;
	logic [1:0] unit_q;
	logic [1:0] mains_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			diag_q <= 1'b0;
			open_q <= rtdib_pkg::OPEN_RST[3:0];
			unit_q <= rtdib_pkg::UNIT_C;
			mains_q <= rtdib_pkg::MAINS_50;
		end else if (wr_ok) begin
			unique case (par_pos)
				rtdib_pkg::IDX_DIAG: diag_q <= par_wdata[rtdib_pkg::DIAG_BIT];
				rtdib_pkg::IDX_OPEN: open_q <= par_wdata[3:0];
				rtdib_pkg::IDX_UNIT: unit_q <= par_wdata[1:0];
				rtdib_pkg::IDX_MAINS: mains_q <= par_wdata[1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				rng_q[i] <= rtdib_pkg::RANGE_RST;
			end
		end else if (init_cnt_q == 2'(rtdib_pkg::STRAP_WAIT - 2'h1)) begin
			// Taken only once the second synchroniser stage holds the pin level
			if (strap_s2_q) begin
				rng_q[2] <= rtdib_pkg::RANGE_OFF;
				rng_q[3] <= rtdib_pkg::RANGE_OFF;
			end
		end else if (wr_ok && par_pos >= rtdib_pkg::IDX_CH0) begin
			rng_q[wr_ch] <= par_wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chan_param_err <= 4'h0;
		end else if (par_wr && init_done && set_ok && par_pos >= rtdib_pkg::IDX_CH0) begin
			chan_param_err[wr_ch] <= !data_ok;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			par_wack <= 1'b0;
			par_werr <= 1'b0;
		end else begin
			par_wack <= wr_ok;
			par_werr <= par_wr && !wr_ok;
		end
	end

	// ---------------------------------------------------------------
	// Read back
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			par_rvalid <= 1'b0;
			par_rdata <= 8'h00;
		end else begin
			par_rvalid <= par_rd;
			if (par_rd) begin
				unique case (par_pos)
					rtdib_pkg::IDX_DIAG: par_rdata <= diag_q ? rtdib_pkg::DIAG_ON : rtdib_pkg::DIAG_OFF;
					rtdib_pkg::IDX_OPEN: par_rdata <= {4'h0, open_q};
					rtdib_pkg::IDX_UNIT: par_rdata <= {6'h00, unit_q};
					rtdib_pkg::IDX_MAINS: par_rdata <= {6'h00, mains_q};
					default: par_rdata <= rng_q[wr_ch];
				endcase
			end
		end
	end

	assign diag_irq_en = diag_q;
	assign open_circuit_en = open_q;
	assign temp_unit = unit_q;
	assign mains_60hz = mains_q == rtdib_pkg::MAINS_60;

	// ---------------------------------------------------------------
	// Process value path
	// ---------------------------------------------------------------
	logic [15:0] sc_value;
	logic sc_over;
	logic sc_under;
	logic sc_clamped;

	rtdib_scale u_scale (
		.cls(cls[meas_chan]),
		.unit(unit_q),
		.raw(meas_raw),
		.value(sc_value),
		.over(sc_over),
		.under(sc_under),
		.clamped(sc_clamped)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pv_valid <= 1'b0;
			pv_chan <= 2'h0;
			pv_value <= 16'h0000;
			pv_over <= 1'b0;
			pv_under <= 1'b0;
			pv_clamped <= 1'b0;
		end else begin
			// Switched off or misconfigured channels yield nothing
			pv_valid <= meas_valid && chan_active[meas_chan];
			if (meas_valid && chan_active[meas_chan]) begin
				pv_chan <= meas_chan;
				pv_value <= sc_value;
				pv_over <= sc_over;
				pv_under <= sc_under;
				pv_clamped <= sc_clamped;
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_diag_on_wr;
		par_wr && init_done && sys_stopped && par_pos == rtdib_pkg::IDX_DIAG
			&& record_set_number == rtdib_pkg::SET_ENABLES && par_wdata == rtdib_pkg::DIAG_ON;
	endsequence

	sequence s_range_wr;
		wr_ok && par_pos >= rtdib_pkg::IDX_CH0;
	endsequence

	a_diag_enable: assert property (s_diag_on_wr |=> diag_irq_en && par_wack)
		else $error("interrupt enable write not taken");
	a_enable_stop: assert property (
		par_wr && !sys_stopped && par_pos < rtdib_pkg::IDX_UNIT
		|=> par_werr && $stable(open_circuit_en) && $stable(diag_irq_en))
		else $error("enable record accepted while running");
	a_diag_code: assert property (
		par_wr && par_pos == rtdib_pkg::IDX_DIAG && par_wdata != rtdib_pkg::DIAG_OFF
		&& par_wdata != rtdib_pkg::DIAG_ON |=> par_werr && $stable(diag_irq_en))
		else $error("illegal interrupt byte accepted");
	a_open_mask: assert property (
		wr_ok && par_pos == rtdib_pkg::IDX_OPEN
		|=> open_circuit_en == $past(par_wdata[3:0]))
		else $error("open circuit mask wrong");
	a_unit_code: assert property (
		par_wr && par_pos == rtdib_pkg::IDX_UNIT && par_wdata[1:0] == 2'h3
		|=> par_werr && $stable(temp_unit))
		else $error("illegal unit code accepted");
	a_mains_code: assert property (
		par_wr && par_pos == rtdib_pkg::IDX_MAINS && par_wdata[1:0] == 2'h0
		|=> par_werr && $stable(mains_60hz))
		else $error("illegal rejection code accepted");
	a_off_silent: assert property (
		meas_valid && rng_q[meas_chan] == rtdib_pkg::RANGE_OFF
		|=> !pv_valid)
		else $error("switched off channel reported");
	a_strap_init: assert property (
		$rose(init_done) && strap_s2_q
		|-> rng_q[2] == rtdib_pkg::RANGE_OFF && rng_q[3] == rtdib_pkg::RANGE_OFF)
		else $error("two channel default missing");
	a_range_store: assert property (
		s_range_wr |=> rng_q[$past(wr_ch)] == $past(par_wdata))
		else $error("range code not stored");
	a_pt_band: assert property (
		pv_valid && cls[pv_chan] == rtdib_pkg::CLS_PT && temp_unit == rtdib_pkg::UNIT_C
		|-> $signed(pv_value) <= 16'sd10000 && $signed(pv_value) >= -16'sd2430)
		else $error("platinum value outside band");
	a_ni_band: assert property (
		pv_valid && cls[pv_chan] == rtdib_pkg::CLS_NI && temp_unit == rtdib_pkg::UNIT_C
		|-> $signed(pv_value) <= 16'sd2950 && $signed(pv_value) >= -16'sd1050)
		else $error("nickel value outside band");
	a_n120_band: assert property (
		pv_valid && cls[pv_chan] == rtdib_pkg::CLS_N120 && temp_unit == rtdib_pkg::UNIT_C
		|-> $signed(pv_value) <= 16'sd4000 && $signed(pv_value) >= -16'sd1000)
		else $error("nickel 120 value outside band");
	a_res_span: assert property (
		pv_valid && cls[pv_chan] == rtdib_pkg::CLS_RES |-> !pv_value[15])
		else $error("resistance value negative");
	a_set_match: assert property (
		par_wr && record_set_number != exp_set |=> par_werr && !par_wack)
		else $error("write in wrong record set accepted");
	a_res_band: assert property (
		meas_valid && cls[meas_chan] == rtdib_pkg::CLS_RES && chan_active[meas_chan]
		&& meas_raw < 18'sd0 |=> pv_value == 16'h0000 && pv_clamped && pv_under)
		else $error("resistance underflow not clamped");
	a_bad_code: assert property (
		par_wr && init_done && set_ok && par_pos >= rtdib_pkg::IDX_CH0
		&& wr_cls == rtdib_pkg::CLS_BAD |=> par_werr && chan_param_err[$past(wr_ch)])
		else $error("unknown range code accepted");
endmodule : rtdib_param

// [rtdib_host.sv]
// Head module model issuing parameter record accesses
`timescale 1ns/10ps
module rtdib_host (
	input wire logic clk,
	output logic sys_stopped,
	output logic par_wr,
	output logic par_rd,
	output logic [2:0] par_pos,
	output logic [7:0] record_set_number,
	output logic [7:0] par_wdata,
	input wire logic par_wack,
	input wire logic par_werr,
	input wire logic par_rvalid,
	input wire logic [7:0] par_rdata
);
	// ---------------------------------------------------------------
	// After an access the address, and after a write also set and data, go inverted so stale data is never reused
	// ---------------------------------------------------------------
	initial begin
		sys_stopped = 1'h1;
		par_wr = 1'h0;
		par_rd = 1'h0;
		par_pos = 3'h0;
		record_set_number = 8'h00;
		par_wdata = 8'h00;
	end
	task automatic wr(input logic [2:0] pos, input logic [7:0] set, input logic [7:0] d,
		input logic stp, output logic [1:0] resp);
		@(posedge clk);
		sys_stopped <= stp;
		par_wr <= 1'h1;
		par_pos <= pos;
		record_set_number <= set;
		par_wdata <= d;
		@(posedge clk);
		par_wr <= 1'h0;
		par_pos <= ~pos;
		record_set_number <= ~set;
		par_wdata <= ~d;
		#1;
		resp = {par_werr, par_wack};
	endtask : wr
	task automatic rd(input logic [2:0] pos, output logic ok, output logic [7:0] d);
		@(posedge clk);
		par_rd <= 1'h1;
		par_pos <= pos;
		@(posedge clk);
		par_rd <= 1'h0;
		par_pos <= ~pos;
		#1;
		ok = par_rvalid;
		d = par_rdata;
	endtask : rd
endmodule : rtdib_host

// [tb_top.sv]
// Self-checking bench of the parameter block
`timescale 1ns/10ps
module tb_top;
	logic clk, sys_rst, two_ch_strap, sys_stopped, par_wr, par_rd, par_wack, par_werr;
	logic par_rvalid, diag_irq_en, mains_60hz, meas_valid, pv_valid, pv_over, pv_under;
	logic pv_clamped, ok;
	logic [2:0] par_pos;
	logic [7:0] record_set_number, par_wdata, par_rdata, rdat;
	logic [3:0] open_circuit_en, chan_active, chan_param_err;
	logic [1:0] temp_unit, meas_chan, pv_chan, resp;
	logic signed [17:0] meas_raw;
	logic [15:0] pv_value;
	int mismatches, checked;
	logic [7:0] dflt [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h50, 8'h50, 8'h50, 8'h50};
	logic [7:0] good [16] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h58, 8'h5c, 8'h60,
		8'h64, 8'h70, 8'h72, 8'h78, 8'h7a, 8'h80, 8'h82, 8'hff};
	logic [7:0] bad [6] = '{8'h55, 8'h5d, 8'h65, 8'h73, 8'h7b, 8'h83};
	// ---------------------------------------------------------------
	// Design, head module model and clock
	// ---------------------------------------------------------------
	rtdib_param rtdib_param_i (.clk(clk), .sys_rst(sys_rst), .two_ch_strap(two_ch_strap),
		.sys_stopped(sys_stopped), .par_wr(par_wr), .par_rd(par_rd), .par_pos(par_pos),
		.record_set_number(record_set_number), .par_wdata(par_wdata), .par_wack(par_wack),
		.par_werr(par_werr), .par_rvalid(par_rvalid), .par_rdata(par_rdata),
		.diag_irq_en(diag_irq_en), .open_circuit_en(open_circuit_en), .temp_unit(temp_unit),
		.mains_60hz(mains_60hz), .chan_active(chan_active), .chan_param_err(chan_param_err),
		.meas_valid(meas_valid), .meas_chan(meas_chan), .meas_raw(meas_raw),
		.pv_valid(pv_valid), .pv_chan(pv_chan), .pv_value(pv_value), .pv_over(pv_over),
		.pv_under(pv_under), .pv_clamped(pv_clamped));
	rtdib_host rtdib_host_i (.clk(clk), .sys_stopped(sys_stopped), .par_wr(par_wr),
		.par_rd(par_rd), .par_pos(par_pos), .record_set_number(record_set_number),
		.par_wdata(par_wdata), .par_wack(par_wack), .par_werr(par_werr),
		.par_rvalid(par_rvalid), .par_rdata(par_rdata));
	always #10 clk = ~clk;
	// ---------------------------------------------------------------
	// Access and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr_chk(input logic [2:0] pos, input logic [7:0] set, input logic [7:0] d,
		input logic stp, input logic [1:0] er);
		rtdib_host_i.wr(pos, set, d, stp, resp);
		chk("write response", 32'(resp), 32'(er));
	endtask : wr_chk
	task automatic rd_chk(input logic [2:0] pos, input logic [7:0] er);
		rtdib_host_i.rd(pos, ok, rdat);
		chk("read valid", 32'(ok), 32'h1);
		chk("read byte", 32'(rdat), 32'(er));
	endtask : rd_chk
	// Measures channel 0 with the given range code and unit
	task automatic meas_chk(input logic [7:0] code, input logic [1:0] u, input logic [17:0] raw,
		input logic [15:0] ev, input logic [2:0] ef);
		wr_chk(3'h4, 8'h80, code, 1'h1, 2'h1);
		wr_chk(3'h2, 8'h01, {6'h00, u}, 1'h1, 2'h1);
		@(posedge clk);
		meas_valid <= 1'h1;
		meas_chan <= 2'h0;
		meas_raw <= raw;
		@(posedge clk);
		meas_valid <= 1'h0;
		meas_raw <= ~raw;
		#1;
		chk("pv valid", 32'(pv_valid), 32'h1);
		chk("pv channel", 32'(pv_chan), 32'h0);
		chk("pv value", 32'(pv_value), 32'(ev));
		chk("pv flags", 32'({pv_over, pv_under, pv_clamped}), 32'(ef));
	endtask : meas_chk
	task automatic do_reset(input logic strap);
		sys_rst <= 1'h1;
		two_ch_strap <= strap;
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
	endtask : do_reset
	task automatic summarize;
		$display("Comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	// ---------------------------------------------------------------
	// Watchdog: a hang counts as a mismatch
	// ---------------------------------------------------------------
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
	initial begin
		clk = 1'h0;
		sys_rst = 1'h1;
		two_ch_strap = 1'h0;
		meas_valid = 1'h0;
		meas_chan = 2'h0;
		meas_raw = 18'h00000;
		mismatches = 0;
		checked = 0;
		do_reset(1'h0);
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rd_chk(3'(i), dflt[i]);
		end
		chk("channels on", 32'(chan_active), 32'hf);
		wr_chk(3'h0, 8'h00, 8'h40, 1'h1, 2'h1);
		chk("diag", 32'(diag_irq_en), 32'h1);
		rd_chk(3'h0, 8'h40);
		wr_chk(3'h0, 8'h00, 8'h41, 1'h1, 2'h2);
		wr_chk(3'h0, 8'h00, 8'h00, 1'h0, 2'h2);
		chk("diag", 32'(diag_irq_en), 32'h1);
		wr_chk(3'h0, 8'h00, 8'h00, 1'h1, 2'h1);
		chk("diag", 32'(diag_irq_en), 32'h0);
		wr_chk(3'h1, 8'h00, 8'hf5, 1'h1, 2'h1);
		chk("open", 32'(open_circuit_en), 32'h5);
		rd_chk(3'h1, 8'h05);
		for (int u = 0; u < 3; u++) begin
			wr_chk(3'h2, 8'h01, {6'h3f, 2'(u)}, 1'h1, 2'h1);
			chk("unit", 32'(temp_unit), 32'(u));
			rd_chk(3'h2, {6'h00, 2'(u)});
		end
		wr_chk(3'h2, 8'h01, 8'h03, 1'h1, 2'h2);
		wr_chk(3'h2, 8'h00, 8'h00, 1'h1, 2'h2);
		wr_chk(3'h3, 8'h01, 8'hfd, 1'h1, 2'h1);
		chk("mains", 32'(mains_60hz), 32'h1);
		wr_chk(3'h3, 8'h01, 8'h02, 1'h1, 2'h1);
		chk("mains", 32'(mains_60hz), 32'h0);
		wr_chk(3'h3, 8'h01, 8'h00, 1'h1, 2'h2);
		foreach (good[i]) begin
			wr_chk(3'h5, 8'h81, good[i], 1'h1, 2'h1);
			chk("active", 32'(chan_active[1]), 32'(good[i] != 8'hff));
			chk("param err", 32'(chan_param_err[1]), 32'h0);
		end
		foreach (bad[i]) begin
			wr_chk(3'h5, 8'h81, bad[i], 1'h1, 2'h2);
			chk("param err", 32'(chan_param_err[1]), 32'h1);
			rd_chk(3'h5, 8'hff);
		end
		wr_chk(3'h5, 8'h80, 8'h50, 1'h1, 2'h2);
		wr_chk(3'h7, 8'h83, 8'hff, 1'h1, 2'h1);
		@(posedge clk);
		meas_valid <= 1'h1;
		meas_chan <= 2'h3;
		@(posedge clk);
		meas_valid <= 1'h0;
		#1;
		chk("pv valid off", 32'(pv_valid), 32'h0);
		meas_chk(8'h50, 2'h0, 18'h02134, 16'h2134, 3'h0);
		meas_chk(8'h51, 2'h0, 18'h02135, 16'h2135, 3'h4);
		meas_chk(8'h58, 2'h0, 18'h02711, 16'h2710, 3'h5);
		meas_chk(8'h60, 2'h0, 18'h3f681, 16'hf682, 3'h3);
		meas_chk(8'h52, 2'h0, 18'h00bb8, 16'h0b86, 3'h5);
		meas_chk(8'h53, 2'h0, 18'h3fda8, 16'hfda8, 3'h0);
		meas_chk(8'h54, 2'h0, 18'h3fc17, 16'hfc18, 3'h3);
		meas_chk(8'h64, 2'h0, 18'h00c81, 16'h0c81, 3'h4);
		meas_chk(8'h70, 2'h0, 18'h09c40, 16'h7fff, 3'h5);
		meas_chk(8'h82, 2'h0, 18'h3fffb, 16'h0000, 3'h3);
		meas_chk(8'h50, 2'h1, 18'h003e8, 16'h0848, 3'h0);
		meas_chk(8'h50, 2'h1, 18'h3f830, 16'hf330, 3'h0);
		meas_chk(8'h50, 2'h2, 18'h00000, 16'h0aac, 3'h0);
		do_reset(1'h1);
		wr_chk(3'h2, 8'h01, 8'h00, 1'h1, 2'h2);
		rd_chk(3'h6, 8'hff);
		rd_chk(3'h7, 8'hff);
		rd_chk(3'h4, 8'h50);
		chk("channels on", 32'(chan_active), 32'h3);
		summarize();
	end
endmodule : tb_top
